// ===== rtl/dac_front_pkg.sv
package dac_front_pkg;

    // ------------------------------------------------------------------
    // Frame and channel geometry
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 32;
    localparam int BIT_CNT_W = 6;
    localparam logic [5:0] LAST_BIT = 6'h1f;
    localparam int CHANNELS = 8;
    localparam int CHAN_W = 3;
    localparam int DAC_W = 16;

    // ------------------------------------------------------------------
    // Clear-code setting
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CLR_ZERO = 2'b00,
        CLR_MID = 2'b01,
        CLR_FULL = 2'b10,
        CLR_SPARE = 2'b11
    } clear_code_t;

    localparam clear_code_t CLEAR_CODE_RESET = CLR_ZERO;
    localparam logic [DAC_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [DAC_W-1:0] CODE_MID = 16'h8000;
    localparam logic [DAC_W-1:0] CODE_FULL = 16'hffff;

    // Clock of the block, for reference by timing figures.
    localparam int SYS_CLK_PERIOD_NS = 25;

endpackage

// ===== rtl/frame_word_if.sv
`timescale 1ns/1ps

interface frame_word_if;
    logic [dac_front_pkg::WORD_BITS-1:0] word;
    logic valid;
    logic busy;

    modport source
    (
        output word,
        output valid,
        output busy
    );

    modport sink
    (
        input word,
        input valid,
        input busy
    );
endinterface

// ===== rtl/serial_frame_rx.sv
`timescale 1ns/1ps

module serial_frame_rx
(
    input wire logic sys_clk_i, // Block clock.
    input wire logic rst_n_i, // Synchronous reset, active low.
    input wire logic frame_sel_n_i, // Frame select pin, active low.
    input wire logic shift_clk_i, // Serial shift clock pin.
    input wire logic data_i, // Serial data pin.
    frame_word_if.source out_if // Captured word toward the core.
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sel_sync;
    logic [1:0] sclk_sync;
    logic [1:0] din_sync;
    logic sel_prev;
    logic sclk_prev;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            sel_sync <= 2'b11;
            sclk_sync <= 2'b00;
            din_sync <= 2'b00;
        end
        else
        begin
            sel_sync <= {sel_sync[0], frame_sel_n_i};
            sclk_sync <= {sclk_sync[0], shift_clk_i};
            din_sync <= {din_sync[0], data_i};
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            sel_prev <= 1'b1;
            sclk_prev <= 1'b0;
        end
        else
        begin
            sel_prev <= sel_sync[1];
            sclk_prev <= sclk_sync[1];
        end
    end

    logic sel_fall;
    logic sel_rise;
    logic sclk_fall;
    assign sel_fall = sel_prev && !sel_sync[1];
    assign sel_rise = !sel_prev && sel_sync[1];
    assign sclk_fall = sclk_prev && !sclk_sync[1];

    // ------------------------------------------------------------------
    // Shift register and bit count
    // ------------------------------------------------------------------
    logic armed;
    logic [dac_front_pkg::BIT_CNT_W-1:0] bit_cnt;
    logic [dac_front_pkg::WORD_BITS-1:0] shift_reg;

    // Data and clock share the same synchroniser depth, so the data bit
    // seen at a detected falling edge is the one set up before it.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            armed <= 1'b0;
            bit_cnt <= '0;
        end
        else if (sel_fall)
        begin
            armed <= 1'b1;
            bit_cnt <= '0;
        end
        else if (sel_rise)
        begin
            armed <= 1'b0;
            bit_cnt <= '0;
        end
        else if (armed && sclk_fall)
        begin
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == dac_front_pkg::LAST_BIT)
            begin
                armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            shift_reg <= '0;
        end
        else if (armed && sclk_fall)
        begin
            shift_reg <= {shift_reg[dac_front_pkg::WORD_BITS-2:0], din_sync[1]};
        end
    end

    // ------------------------------------------------------------------
    // Word hand-off
    // ------------------------------------------------------------------
    logic word_done;
    assign word_done = armed && sclk_fall && !sel_rise && !sel_fall
        && (bit_cnt == dac_front_pkg::LAST_BIT);

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            out_if.word <= '0;
            out_if.valid <= 1'b0;
        end
        else
        begin
            out_if.valid <= word_done;
            if (word_done)
            begin
                out_if.word <= {shift_reg[dac_front_pkg::WORD_BITS-2:0], din_sync[1]};
            end
        end
    end

    assign out_if.busy = armed;

endmodule

// ===== rtl/octal_dac_front.sv
`timescale 1ns/1ps

module octal_dac_front
#(
    parameter int CHANNELS = dac_front_pkg::CHANNELS,
    parameter int DAC_W = dac_front_pkg::DAC_W
)
(
    input wire logic sys_clk_i, // Block clock, 40 MHz.
    input wire logic rst_n_i, // Synchronous reset, active low.
    input wire logic frame_sel_n_i, // Frame select pin, active low.
    input wire logic shift_clk_i, // Serial shift clock pin.
    input wire logic data_i, // Serial data pin.
    input wire logic load_strobe_n_i, // Load strobe pin, active low.
    input wire logic async_clear_n_i, // Clear pin, falling edge active.
    input wire logic input_wr_i, // Decoder: write one input register.
    input wire logic [dac_front_pkg::CHAN_W-1:0] input_sel_i, // Decoder: channel to write.
    input wire logic [DAC_W-1:0] input_data_i, // Decoder: value to write.
    input wire logic clear_code_wr_i, // Decoder: update clear-code setting.
    input wire logic [1:0] clear_code_i, // Decoder: new clear-code setting.
    output logic [dac_front_pkg::WORD_BITS-1:0] word_o, // Last complete serial word.
    output logic word_valid_o, // One-cycle pulse with a new word.
    output logic frame_busy_o, // Frame armed and shifting.
    output logic [CHANNELS*DAC_W-1:0] input_value_o, // Input registers, packed.
    output logic [CHANNELS*DAC_W-1:0] dac_value_o, // DAC registers, packed.
    output logic [CHANNELS-1:0] pending_o, // Input register holds new data.
    output logic [1:0] clear_code_o // Current clear-code setting.
);

    // ------------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------------
    frame_word_if rx_if();

    serial_frame_rx u_rx
    (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .frame_sel_n_i(frame_sel_n_i),
        .shift_clk_i(shift_clk_i),
        .data_i(data_i),
        .out_if(rx_if.source)
    );

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            word_o <= '0;
            word_valid_o <= 1'b0;
        end
        else
        begin
            word_valid_o <= rx_if.valid;
            if (rx_if.valid)
            begin
                word_o <= rx_if.word;
            end
        end
    end

    assign frame_busy_o = rx_if.busy;

    // ------------------------------------------------------------------
    // Load and clear pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] load_sync;
    logic [1:0] clear_sync;
    logic clear_prev;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            load_sync <= 2'b11;
            clear_sync <= 2'b11;
            clear_prev <= 1'b1;
        end
        else
        begin
            load_sync <= {load_sync[0], load_strobe_n_i};
            clear_sync <= {clear_sync[0], async_clear_n_i};
            clear_prev <= clear_sync[1];
        end
    end

    // The clear is sampled by the block clock and never by the shift clock,
    // so a clear lands whether or not a frame is running.
    logic clear_fall;
    logic clear_low;
    logic load_active;
    assign clear_fall = clear_prev && !clear_sync[1];
    assign clear_low = !clear_sync[1];
    // A level, not an edge: a tied-low strobe then acts as a transparent latch.
    assign load_active = !load_sync[1] && !clear_low;

    // ------------------------------------------------------------------
    // Clear-code setting
    // ------------------------------------------------------------------
    dac_front_pkg::clear_code_t clear_code;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            clear_code <= dac_front_pkg::CLEAR_CODE_RESET;
        end
        else if (clear_code_wr_i)
        begin
            clear_code <= dac_front_pkg::clear_code_t'(clear_code_i);
        end
    end

    assign clear_code_o = clear_code;

    function automatic logic [DAC_W-1:0] clear_value(input dac_front_pkg::clear_code_t code);
        logic [DAC_W-1:0] v;
        v = dac_front_pkg::CODE_ZERO;
        unique case (code)
            dac_front_pkg::CLR_ZERO: v = dac_front_pkg::CODE_ZERO;
            dac_front_pkg::CLR_MID: v = dac_front_pkg::CODE_MID;
            dac_front_pkg::CLR_FULL: v = dac_front_pkg::CODE_FULL;
            // The spare code clears to zero rather than leaving old data.
            dac_front_pkg::CLR_SPARE: v = dac_front_pkg::CODE_ZERO;
        endcase
        return v;
    endfunction

    logic [DAC_W-1:0] clear_word;
    assign clear_word = clear_value(clear_code);

    // ------------------------------------------------------------------
    // Input registers, pending flags and DAC registers
    // ------------------------------------------------------------------
    logic [DAC_W-1:0] input_reg [CHANNELS];
    logic [DAC_W-1:0] dac_reg [CHANNELS];
    logic [CHANNELS-1:0] pending;

    // A write arriving in the same cycle as a transfer survives as pending,
    // so new data is never lost to the strobe that just fired.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                input_reg[i] <= '0;
            end
        end
        else if (clear_fall)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                input_reg[i] <= clear_word;
            end
        end
        else if (input_wr_i)
        begin
            input_reg[input_sel_i] <= input_data_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            pending <= '0;
        end
        else if (clear_fall)
        begin
            pending <= '0;
        end
        else
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (input_wr_i && (input_sel_i == i[dac_front_pkg::CHAN_W-1:0]))
                begin
                    pending[i] <= 1'b1;
                end
                else if (load_active)
                begin
                    pending[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                dac_reg[i] <= '0;
            end
        end
        else if (clear_fall)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                dac_reg[i] <= clear_word;
            end
        end
        else if (load_active)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (pending[i])
                begin
                    dac_reg[i] <= input_reg[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Packed outputs
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < CHANNELS; i++)
        begin
            input_value_o[i*DAC_W +: DAC_W] = input_reg[i];
            dac_value_o[i*DAC_W +: DAC_W] = dac_reg[i];
        end
    end

    assign pending_o = pending;

endmodule

// ===== verification/dac_front_checker_sva.sv
`timescale 1ns/1ps

module dac_front_checker
#(
    parameter int CHANNELS = 8,
    parameter int DAC_W = 16
)
(
    input wire logic sys_clk_i, // Block clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire logic frame_sel_n_i, // Frame select.
    input wire logic load_strobe_n_i, // Load strobe.
    input wire logic async_clear_n_i, // Clear pin.
    input wire logic input_wr_i, // Input write.
    input wire logic [dac_front_pkg::CHAN_W-1:0] input_sel_i, // Channel.
    input wire logic [DAC_W-1:0] input_data_i, // Value.
    input wire logic [dac_front_pkg::WORD_BITS-1:0] word_o, // Word.
    input wire logic word_valid_o, // Word pulse.
    input wire logic frame_busy_o, // Frame busy.
    input wire logic [CHANNELS*DAC_W-1:0] input_value_o, // Input registers.
    input wire logic [CHANNELS*DAC_W-1:0] dac_value_o, // DAC registers.
    input wire logic [CHANNELS-1:0] pending_o, // New-data flags.
    input wire logic [1:0] clear_code_o // Clear code.
);
    logic [DAC_W-1:0] clr_val;
    logic [2:0] quiet;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    always_comb
    begin
        case (clear_code_o)
            2'h1: clr_val = dac_front_pkg::CODE_MID;
            2'h2: clr_val = dac_front_pkg::CODE_FULL;
            default: clr_val = dac_front_pkg::CODE_ZERO;
        endcase
    end

    // Pin synchronisers delay a load or clear by a few cycles, so a little slack is allowed.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i || !load_strobe_n_i || !async_clear_n_i)
        begin
            quiet <= 3'h0;
        end
        else if (quiet != 3'h7)
        begin
            quiet <= quiet + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_busy_arm;
        $fell(frame_sel_n_i) |-> ##[2:4] frame_busy_o;
    endproperty
    a_busy_arm: assert property (p_busy_arm) else $error("frame not armed");

    property p_valid_after_busy;
        word_valid_o |-> $past(frame_busy_o, 2) && !$past(frame_busy_o);
    endproperty
    a_valid_after_busy: assert property (p_valid_after_busy) else $error("stray word");

    property p_valid_pulse;
        word_valid_o |=> !word_valid_o;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("word pulse too long");

    property p_word_hold;
        !word_valid_o |-> $stable(word_o);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word changed alone");

    property p_pending_set;
        input_wr_i |=> pending_o[$past(input_sel_i)]
            && input_value_o[$past(input_sel_i)*DAC_W +: DAC_W] == $past(input_data_i);
    endproperty
    a_pending_set: assert property (p_pending_set) else $error("write lost");

    property p_dac_cause;
        !$stable(dac_value_o) |-> quiet < 3'h6;
    endproperty
    a_dac_cause: assert property (p_dac_cause) else $error("dac moved alone");

    property p_load_copies;
        (!load_strobe_n_i && async_clear_n_i && !input_wr_i) [*5] |=> pending_o == '0;
    endproperty
    a_load_copies: assert property (p_load_copies) else $error("load left data");

    property p_clear_blocks;
        (!async_clear_n_i) [*8] |=> $stable(dac_value_o);
    endproperty
    a_clear_blocks: assert property (p_clear_blocks) else $error("load during clear");

    property p_clear_loads;
        $fell(async_clear_n_i) |-> ##[2:5] (dac_value_o == {CHANNELS{clr_val}}
            && input_value_o == {CHANNELS{clr_val}} && pending_o == '0);
    endproperty
    a_clear_loads: assert property (p_clear_loads) else $error("clear value wrong");

    c_word: cover property ($rose(word_valid_o));
    c_clear: cover property ($fell(async_clear_n_i));
    c_load: cover property (!load_strobe_n_i && pending_o != '0);
endmodule

bind octal_dac_front dac_front_checker #(.CHANNELS(CHANNELS), .DAC_W(DAC_W)) u_checker
(
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .frame_sel_n_i(frame_sel_n_i),
    .load_strobe_n_i(load_strobe_n_i), .async_clear_n_i(async_clear_n_i),
    .input_wr_i(input_wr_i), .input_sel_i(input_sel_i), .input_data_i(input_data_i),
    .word_o(word_o), .word_valid_o(word_valid_o), .frame_busy_o(frame_busy_o),
    .input_value_o(input_value_o), .dac_value_o(dac_value_o), .pending_o(pending_o),
    .clear_code_o(clear_code_o)
);

// ===== verification/host_link_model.sv
`timescale 1ns/1ps

module host_link_model
(
    output logic frame_sel_n_o, // Frame select, active low.
    output logic shift_clk_o, // Shift clock, idle high.
    output logic data_o // Serial data.
);
    initial
    begin
        frame_sel_n_o = 1'b1;
        shift_clk_o = 1'b1;
        data_o = 1'b0;
    end

    // Sends bits of w MSB first, one per falling shift clock; under 32 falls aborts.
    task automatic send(input logic [31:0] w, input int nfall);
        #1;
        frame_sel_n_o = 1'b0;
        for (int i = 0; i < nfall; i++)
        begin
            data_o = w[31 - (i % 32)];
            #100;
            shift_clk_o = 1'b0;
            #100;
            shift_clk_o = 1'b1;
        end
        // Data turns over after the last clock rise, before select is released, so a stale bit cannot pass for a held one.
        data_o = ~data_o;
        #100;
        frame_sel_n_o = 1'b1;
        #200;
    endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic sys_clk;
    logic rst_n;
    logic frame_sel_n;
    logic shift_clk;
    logic data;
    logic load_n;
    logic clr_n;
    logic wr;
    logic [2:0] sel;
    logic [15:0] wdata;
    logic cc_wr;
    logic [1:0] cc;
    logic [31:0] word;
    logic word_valid;
    logic busy;
    logic [127:0] in_val;
    logic [127:0] dac_val;
    logic [7:0] pending;
    logic [1:0] code;
    int fails = 0;
    int n_compared = 0;

    host_link_model HOST (.frame_sel_n_o(frame_sel_n), .shift_clk_o(shift_clk), .data_o(data));

    octal_dac_front DUT
    (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .frame_sel_n_i(frame_sel_n),
        .shift_clk_i(shift_clk), .data_i(data), .load_strobe_n_i(load_n),
        .async_clear_n_i(clr_n), .input_wr_i(wr), .input_sel_i(sel), .input_data_i(wdata),
        .clear_code_wr_i(cc_wr), .clear_code_i(cc), .word_o(word), .word_valid_o(word_valid),
        .frame_busy_o(busy), .input_value_o(in_val), .dac_value_o(dac_val),
        .pending_o(pending), .clear_code_o(code)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr_chan(input logic [2:0] ch, input logic [15:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        sel <= ch;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic frame(input logic [31:0] w, input int nfall, input int np,
        input logic [31:0] exp_word);
        int pulses;
        int guard;
        bit done;
        bit saw_busy;
        pulses = 0;
        guard = 0;
        done = 0;
        saw_busy = 0;
        fork
            begin
                HOST.send(w, nfall);
                done = 1;
            end
            while (!done && guard < 1000)
            begin
                @(posedge sys_clk);
                guard++;
                if (word_valid === 1'b1)
                    pulses++;
                if (busy === 1'b1)
                    saw_busy = 1;
            end
        join
        // A frame that outlasts its bound is counted as a failure.
        if (guard >= 1000)
            fails++;
        check(pulses, np);
        check(word, exp_word);
        check(saw_busy, 1'b1);
        check(busy, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_frames();
        frame(32'ha5c3_0f96, 32, 1, 32'ha5c3_0f96);
        frame(32'h1234_5678, 35, 1, 32'h1234_5678);
        frame(32'hffff_ffff, 31, 0, 32'h1234_5678);
        frame(32'h0000_0001, 32, 1, 32'h0000_0001);
    endtask

    task automatic t_load();
        wr_chan(3'h2, 16'h1111);
        wr_chan(3'h5, 16'h5555);
        step(4);
        check(pending, 8'h24);
        check(dac_val, 128'h0);
        load_n <= 1'b0;
        step(2);
        load_n <= 1'b1;
        step(4);
        check(dac_val, {32'h0, 16'h5555, 32'h0, 16'h1111, 32'h0});
        check(pending, 8'h0);
    endtask

    task automatic t_clear();
        logic [15:0] exp;
        check(code, 2'h0);
        for (int i = 0; i < 4; i++)
        begin
            exp = (i == 1) ? 16'h8000 : (i == 2) ? 16'hffff : 16'h0000;
            if (i > 0)
            begin
                @(posedge sys_clk);
                cc_wr <= 1'b1;
                cc <= 2'(i);
                @(posedge sys_clk);
                cc_wr <= 1'b0;
            end
            wr_chan(3'h0, 16'h1234);
            step(2);
            clr_n <= 1'b0;
            step(8);
            check(in_val, {8{exp}});
            check(dac_val, {8{exp}});
            wr_chan(3'h1, 16'h4321);
            load_n <= 1'b0;
            step(2);
            load_n <= 1'b1;
            step(4);
            check(dac_val, {8{exp}});
            clr_n <= 1'b1;
            step(4);
        end
    endtask

    task automatic t_tied();
        load_n <= 1'b0;
        step(4);
        wr_chan(3'h7, 16'habcd);
        step(4);
        check(dac_val[127:112], 16'habcd);
        check(pending, 8'h0);
    endtask

    initial
    begin
        rst_n = 1'b0;
        load_n = 1'b1;
        clr_n = 1'b1;
        wr = 1'b0;
        sel = 3'h0;
        wdata = 16'h0;
        cc_wr = 1'b0;
        cc = 2'h0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        step(3);
        t_frames();
        t_load();
        t_clear();
        t_tied();
        stop_test();
    end

    initial
    begin
        #2000000;
        fails++;
        stop_test();
    end
endmodule
